// ### rtl/bsiu_consts.svh
// constants of the boundary-scan instruction unit
// Behaviour
// - no boundary test while configuration runs
// - configuration data loads through scan port
// - scan chain rewrites every pin I/O standard
// - sample/preload snapshots pins, preloads pattern
// - extest drives pattern, captures input pins
// - bypass puts one-bit register in path
// - usercode shifts out 32-bit user code
// - idcode shifts out identification register
// - highz selects bypass, floats all pins
// - clamp selects bypass, holds boundary levels
// - pulse opcode requests reconfiguration, pin untouched
// - config-io opcode opens standards, aborts configuration
// - config-io holds status pin low until configured
// - tap follows standard controller and shifting
// - instruction register is ten bits wide
// - identification value lsb always reads one
// - bus-hold or pull-up overrides forced high-z
`ifndef BSIU_CONSTS_SVH
`define BSIU_CONSTS_SVH
`define BSIU_IR_W 10
`define BSIU_OP_EXTEST 10'h000
`define BSIU_OP_PULSE 10'h001
`define BSIU_OP_CFGLOAD 10'h002
`define BSIU_OP_SAMPLE 10'h005
`define BSIU_OP_IDCODE 10'h006
`define BSIU_OP_USER 10'h007
`define BSIU_OP_CLAMP 10'h00a
`define BSIU_OP_HIGHZ 10'h00b
`define BSIU_OP_CFGIO 10'h00d
`define BSIU_OP_BYPASS 10'h3ff
`define BSIU_IR_CAPT 10'h001
`define BSIU_UC_W 32
`define BSIU_BYTE_W 8
`define BSIU_BUF_DEPTH 2
`endif

// ### rtl/bsiu_pkg.sv
// types of the boundary-scan instruction unit
package bsiu_pkg;
  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
    st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_upd_ir
  } bsiu_tap_type;
  typedef enum logic [2:0] {
    dr_byp, dr_bsr, dr_id, dr_user, dr_iostd, dr_cfg
  } bsiu_dr_type;
endpackage

// ### rtl/bsiu_top.sv
// boundary-scan tap, instruction decode, pin control and config data path
`timescale 1ns/10ps
`include "bsiu_consts.svh"
module bsiu_top #(
  parameter int NPINS = 4,
  parameter int STD_W = 2,
  parameter int DATA_W = `BSIU_BYTE_W,
  parameter int DEPTH = `BSIU_BUF_DEPTH,
  parameter logic [31:0] ID_VAL = 32'h0abc_d001 // arbitrary value
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset, high
  input wire logic tck, // scan clock pin
  input wire logic tms, // scan mode pin
  input wire logic tdi, // scan data in pin
  output logic tdo, // scan data out
  output logic tdo_oe, // tdo driven
  input wire logic [NPINS-1:0] pin_in, // pin levels seen
  input wire logic [NPINS-1:0] core_out, // core output data
  input wire logic [NPINS-1:0] core_oe, // core output enables
  input wire logic [NPINS-1:0] hold_en, // bus-hold or pull-up on
  output logic [NPINS-1:0] pin_out, // pin output data
  output logic [NPINS-1:0] pin_oe, // pin output enables
  output logic [NPINS-1:0] pin_keep, // keeper engaged
  output logic [NPINS*STD_W-1:0] io_std, // per-pin io standard
  input wire logic [`BSIU_UC_W-1:0] user_code, // user code
  input wire logic config_busy, // configuration running
  input wire logic cfg_done, // device configured, pulse
  output logic reconfig_pulse, // reconfig request, pulse
  output logic cfg_abort, // stop configuration, pulse
  output logic config_status_out, // status pin level
  output logic config_status_oe, // status pin driven low
  output logic [DATA_W-1:0] cfg_data, // config byte
  output logic cfg_valid, // config byte valid
  input wire logic cfg_ready, // config sink ready
  output logic cfg_overrun // bits lost while full
);
  import bsiu_pkg::*;

  localparam int BSR_L = 2 * NPINS;
  localparam int IOS_L = NPINS * STD_W;
  localparam int SH_W = (BSR_L > IOS_L) ? ((BSR_L > 32) ? BSR_L : 32) :
                        ((IOS_L > 32) ? IOS_L : 32);
  localparam int BC_W = $clog2(DATA_W);
  localparam int PT_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CN_W = $clog2(DEPTH + 1);

  function automatic bsiu_dr_type dr_of(input logic [`BSIU_IR_W-1:0] op);
    if (op == `BSIU_OP_EXTEST || op == `BSIU_OP_SAMPLE) begin
      return dr_bsr;
    end else if (op == `BSIU_OP_IDCODE) begin
      return dr_id;
    end else if (op == `BSIU_OP_USER) begin
      return dr_user;
    end else if (op == `BSIU_OP_CFGIO) begin
      return dr_iostd;
    end else if (op == `BSIU_OP_CFGLOAD) begin
      return dr_cfg;
    end else begin
      return dr_byp;
    end
  endfunction

  function automatic int dr_len(input bsiu_dr_type d);
    case (d)
      dr_bsr: return BSR_L;
      dr_id, dr_user: return `BSIU_UC_W;
      dr_iostd: return IOS_L;
      default: return 1;
    endcase
  endfunction

  function automatic bsiu_tap_type tap_next(input bsiu_tap_type s, input logic m);
    case (s)
      st_reset: return m ? st_reset : st_idle;
      st_idle: return m ? st_sel_dr : st_idle;
      st_sel_dr: return m ? st_sel_ir : st_cap_dr;
      st_cap_dr: return m ? st_ex1_dr : st_sh_dr;
      st_sh_dr: return m ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: return m ? st_upd_dr : st_pa_dr;
      st_pa_dr: return m ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: return m ? st_upd_dr : st_sh_dr;
      st_upd_dr: return m ? st_sel_dr : st_idle;
      st_sel_ir: return m ? st_reset : st_cap_ir;
      st_cap_ir: return m ? st_ex1_ir : st_sh_ir;
      st_sh_ir: return m ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: return m ? st_upd_ir : st_pa_ir;
      st_pa_ir: return m ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: return m ? st_upd_ir : st_sh_ir;
      default: return m ? st_sel_dr : st_idle;
    endcase
  endfunction

  // synchronisers: pins are asynchronous to clk_sys
  logic tck_m, tck_s, tck_d, tms_m, tms_s, tdi_m, tdi_s;
  logic [NPINS-1:0] pin_m, pin_s;
  logic tck_rise, tck_fall;
  always_ff @(posedge clk_sys) begin
    tck_m <= tck;
    tck_s <= tck_m;
    tck_d <= tck_s;
    tms_m <= tms;
    tms_s <= tms_m;
    tdi_m <= tdi;
    tdi_s <= tdi_m;
    pin_m <= pin_in;
    pin_s <= pin_m;
  end
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // tap and scan registers
  bsiu_tap_type state, next_state;
  logic [`BSIU_IR_W-1:0] ir_sh, next_ir_sh, ir, next_ir;
  logic [SH_W-1:0] dr_sh, next_dr_sh, shifted;
  logic byp, next_byp;
  logic [BSR_L-1:0] bsr_upd, next_bsr_upd;
  logic [IOS_L-1:0] next_io_std;
  logic [DATA_W-1:0] asm_b, next_asm_b;
  logic [BC_W-1:0] bitcnt, next_bitcnt;
  logic next_overrun, hold_low, next_hold_low, cfgio_set;
  logic next_reconfig, next_abort, next_tdo, next_tdo_oe;
  logic [NPINS-1:0] next_pin_out, next_pin_oe, next_pin_keep;
  logic push, in_ready, test_ok, drive_upd, hiz;
  bsiu_dr_type dr;
  int cur_len;
  assign dr = dr_of(ir);
  assign cur_len = dr_len(dr);
  assign shifted = dr_sh >> 1;

  always_comb begin
    next_state = state;
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_dr_sh = dr_sh;
    next_byp = byp;
    next_bsr_upd = bsr_upd;
    next_io_std = io_std;
    next_asm_b = asm_b;
    next_bitcnt = bitcnt;
    next_overrun = cfg_overrun;
    next_reconfig = 1'b0;
    next_abort = 1'b0;
    cfgio_set = 1'b0;
    push = 1'b0;
    next_tdo = tdo;
    next_tdo_oe = tdo_oe;
    if (tck_rise) begin
      next_state = tap_next(state, tms_s);
      // load on entry, so no stale instruction keeps acting while the tap sits in reset
      if (next_state == st_reset) begin
        next_ir = `BSIU_OP_IDCODE;
      end
      case (state)
        st_reset: next_overrun = 1'b0;
        st_cap_ir: next_ir_sh = `BSIU_IR_CAPT;
        st_sh_ir: next_ir_sh = {tdi_s, ir_sh[`BSIU_IR_W-1:1]};
        st_upd_ir: begin
          next_ir = ir_sh;
          next_reconfig = (ir_sh == `BSIU_OP_PULSE);
          cfgio_set = (ir_sh == `BSIU_OP_CFGIO);
          next_abort = cfgio_set & config_busy;
        end
        st_cap_dr: begin
          next_byp = 1'b0;
          next_bitcnt = '0;
          next_dr_sh = '0;
          case (dr)
            dr_bsr: next_dr_sh[BSR_L-1:0] = {core_oe, pin_s};
            dr_id: next_dr_sh[`BSIU_UC_W-1:0] = {ID_VAL[31:1], 1'b1};
            dr_user: next_dr_sh[`BSIU_UC_W-1:0] = user_code;
            dr_iostd: next_dr_sh[IOS_L-1:0] = io_std;
            default: next_dr_sh = '0;
          endcase
        end
        st_sh_dr: begin
          next_byp = tdi_s;
          for (int i = 0; i < SH_W; i++) begin
            if (i == cur_len - 1) begin
              next_dr_sh[i] = tdi_s;
            end else if (i < cur_len - 1) begin
              next_dr_sh[i] = shifted[i];
            end
          end
          // the tester cannot be stalled, so a full buffer drops bits
          if (dr == dr_cfg) begin
            if (in_ready) begin
              next_asm_b = {tdi_s, asm_b[DATA_W-1:1]};
              if (bitcnt == BC_W'(DATA_W - 1)) begin
                push = 1'b1;
                next_bitcnt = '0;
              end else begin
                next_bitcnt = bitcnt + 1'b1;
              end
            end else begin
              next_overrun = 1'b1;
            end
          end
        end
        st_upd_dr: begin
          if (dr == dr_bsr) begin
            next_bsr_upd = dr_sh[BSR_L-1:0];
          end else if (dr == dr_iostd) begin
            next_io_std = dr_sh[IOS_L-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      next_tdo = (state == st_sh_ir) ? ir_sh[0] :
                 (dr == dr_byp || dr == dr_cfg) ? byp : dr_sh[0];
      next_tdo_oe = (state == st_sh_ir) || (state == st_sh_dr);
    end
    // a new config-io order wins over a configured report in the same cycle
    next_hold_low = (hold_low & ~cfg_done) | cfgio_set;
    // pins belong to the core while configuration is running
    test_ok = ~config_busy;
    drive_upd = test_ok && (ir == `BSIU_OP_EXTEST || ir == `BSIU_OP_CLAMP);
    hiz = test_ok && (ir == `BSIU_OP_HIGHZ);
    next_pin_out = drive_upd ? bsr_upd[NPINS-1:0] : core_out;
    next_pin_oe = hiz ? '0 : drive_upd ? bsr_upd[BSR_L-1:NPINS] : core_oe;
    next_pin_keep = hold_en & ({NPINS{hiz}} | ({NPINS{drive_upd}} &
                    ~bsr_upd[BSR_L-1:NPINS]));
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= st_reset;
      ir_sh <= '0;
      ir <= `BSIU_OP_IDCODE;
      dr_sh <= '0;
      byp <= 1'b0;
      bsr_upd <= '0;
      io_std <= '0;
      asm_b <= '0;
      bitcnt <= '0;
      cfg_overrun <= 1'b0;
      hold_low <= 1'b0;
      reconfig_pulse <= 1'b0;
      cfg_abort <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      pin_out <= '0;
      pin_oe <= '0;
      pin_keep <= '0;
    end else begin
      state <= next_state;
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      dr_sh <= next_dr_sh;
      byp <= next_byp;
      bsr_upd <= next_bsr_upd;
      io_std <= next_io_std;
      asm_b <= next_asm_b;
      bitcnt <= next_bitcnt;
      cfg_overrun <= next_overrun;
      hold_low <= next_hold_low;
      reconfig_pulse <= next_reconfig;
      cfg_abort <= next_abort;
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_keep <= next_pin_keep;
    end
  end
  assign config_status_out = 1'b0;
  assign config_status_oe = hold_low;

  // two-entry config byte buffer
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PT_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CN_W-1:0] count, next_count;
  logic pop;
  assign in_ready = (count != CN_W'(DEPTH));
  assign cfg_valid = (count != '0);
  assign cfg_data = mem[rd_ptr];
  assign pop = cfg_valid & cfg_ready;
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PT_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PT_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + CN_W'(push) - CN_W'(pop);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (push) begin
        mem[wr_ptr] <= next_asm_b;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ir_reset_id_a: assert property (tck_rise && state == st_reset |=>
    ir == `BSIU_OP_IDCODE) else $error("reset state did not load idcode");
  ir_update_a: assert property (tck_rise && state == st_upd_ir |=>
    ir == $past(ir_sh)) else $error("instruction not updated");
  id_lsb_a: assert property (tck_rise && state == st_cap_dr && dr == dr_id |=>
    dr_sh[0] && dr_sh[31:0] == {ID_VAL[31:1], 1'b1}) else $error("bad id capture");
  user_cap_a: assert property (tck_rise && state == st_cap_dr && dr == dr_user |=>
    dr_sh[31:0] == $past(user_code)) else $error("bad user code capture");
  bypass_path_a: assert property (tck_rise && state == st_sh_dr && dr == dr_byp |=>
    byp == $past(tdi_s)) else $error("bypass bit lost");
  highz_pins_a: assert property (ir == `BSIU_OP_HIGHZ && !config_busy |=>
    pin_oe == '0) else $error("pins driven under highz");
  clamp_hold_a: assert property (ir == `BSIU_OP_CLAMP && !config_busy |=>
    pin_out == $past(bsr_upd[NPINS-1:0])) else $error("clamp level wrong");
  busy_core_a: assert property (config_busy |=> pin_out == $past(core_out) &&
    pin_oe == $past(core_oe)) else $error("test drove pins while busy");
  reconf_once_a: assert property (reconfig_pulse |=> !reconfig_pulse)
    else $error("reconfig pulse too long");
  abort_cfg_a: assert property (tck_rise && state == st_upd_ir &&
    ir_sh == `BSIU_OP_CFGIO && config_busy |=> cfg_abort) else $error("no abort");
  status_low_a: assert property (config_status_oe && !cfg_done |=>
    config_status_oe) else $error("status released early");
  keeper_highz_a: assert property (ir == `BSIU_OP_HIGHZ && !config_busy |=>
    pin_keep == $past(hold_en)) else $error("keeper not engaged");
  buf_bound_a: assert property (count <= CN_W'(DEPTH))
    else $error("buffer count past depth");
  buf_hold_a: assert property (cfg_valid && !cfg_ready |=>
    cfg_valid && $stable(cfg_data)) else $error("buffer head dropped while stalled");
  cover_idcode_c: cover property (tck_rise && state == st_sh_dr && dr == dr_id);
  cover_full_c: cover property (!in_ready ##1 pop);
  cover_cfgio_c: cover property (cfg_abort ##[1:50] config_status_oe);
  cover_extest_c: cover property (ir == `BSIU_OP_EXTEST && tck_rise && state == st_upd_dr);
endmodule

// ### verification/bsiu_host.sv
// scan-port host model: drives link clock, mode and data pins, reads tdo
`timescale 1ns/10ps
module bsiu_host (
  output logic tck, // link clock, low between frames
  output logic tms, // mode pin
  output logic tdi, // data pin
  input wire logic tdo, // data from device
  input wire logic tdo_oe // device drives tdo
);
  logic seen;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tdo is read late in the high phase, after the device's update has settled
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    #76 seen = tdo_oe ? tdo : ~seen;
    #4 tck = 1'b0;
  endtask
  task automatic tap_reset;
    repeat (5) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // idle -> capture -> shift n bits lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = '0;
    step(1'b1, 1'b0);
    if (ir) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = seen;
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule

// ### verification/boundary_scan_instruction_unit_test.sv
// self-checking bench of the boundary-scan instruction unit
`timescale 1ns/10ps
`include "bsiu_consts.svh"
module boundary_scan_instruction_unit_test;
  localparam int N = 4;
  localparam logic [31:0] ID = 32'h0f0f_3c5a; // arbitrary value, even on purpose
  logic clk_sys, rst, tck, tms, tdi, tdo, tdo_oe;
  logic [N-1:0] pin_in, core_out, core_oe, hold_en, pin_out, pin_oe, pin_keep;
  logic [2*N-1:0] io_std;
  logic [31:0] user_code, p, q, d;
  logic config_busy, cfg_done, reconfig_pulse, cfg_abort, cs_out, cs_oe;
  logic [7:0] cfg_data;
  logic cfg_valid, cfg_ready, cfg_overrun;
  int err_total, cmp_count, n_pulse, n_abort;
  logic [9:0] ops [3] = '{10'h3ff, 10'h155, 10'h00b};

  bsiu_top #(.NPINS(N), .STD_W(2), .DATA_W(8), .DEPTH(2), .ID_VAL(ID)) bsiu_top_i (
    .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
    .hold_en(hold_en), .pin_out(pin_out), .pin_oe(pin_oe), .pin_keep(pin_keep),
    .io_std(io_std), .user_code(user_code), .config_busy(config_busy),
    .cfg_done(cfg_done), .reconfig_pulse(reconfig_pulse), .cfg_abort(cfg_abort),
    .config_status_out(cs_out), .config_status_oe(cs_oe), .cfg_data(cfg_data),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_overrun(cfg_overrun));
  bsiu_host bsiu_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (reconfig_pulse === 1'b1) n_pulse++;
    if (cfg_abort === 1'b1) n_abort++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #2;
  endtask
  task automatic ir(input logic [9:0] op);
    bsiu_host_i.scan(1'b1, 10, {22'h0, op}, d);
    chk(d[9:0], `BSIU_IR_CAPT);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    p = $urandom(32'hea6e);
    {pin_in, core_out, core_oe, hold_en} = $urandom;
    user_code = $urandom;
    {config_busy, cfg_done, cfg_ready} = 3'b000;
    repeat (8) tick;
    rst = 1'b0;
    // identification is the default register after reset
    bsiu_host_i.tap_reset();
    bsiu_host_i.scan(1'b0, 32, 32'h0, d);
    chk(d, ID | 32'h1);
    chk(tdo_oe, 1'b0);
    ir(`BSIU_OP_USER);
    bsiu_host_i.scan(1'b0, 32, 32'h0, d);
    chk(d, user_code);
    $display("test ident done");
    // one-bit path: bypass captures zero, then tdi appears one shift later
    foreach (ops[k]) begin
      ir(ops[k]);
      bsiu_host_i.scan(1'b0, 2, 32'h1, d);
      chk(d[1:0], 2'b10);
      if (ops[k] == `BSIU_OP_HIGHZ) begin
        chk({pin_oe, pin_keep}, {{N{1'b0}}, hold_en});
      end else begin
        chk({pin_oe, pin_out}, {core_oe, core_out});
      end
    end
    $display("test bypass done");
    ir(`BSIU_OP_SAMPLE);
    bsiu_host_i.scan(1'b0, 2*N, p, d);
    chk(d[7:0], {core_oe, pin_in});
    chk({pin_oe, pin_out}, {core_oe, core_out});
    ir(`BSIU_OP_EXTEST);
    chk({pin_oe, pin_out}, p[7:0]);
    chk(pin_keep, hold_en & ~p[7:4]);
    bsiu_host_i.scan(1'b0, 2*N, p, d);
    chk(d[7:0], {core_oe, pin_in});
    ir(`BSIU_OP_CLAMP);
    chk({pin_oe, pin_out}, p[7:0]);
    config_busy = 1'b1;
    repeat (3) tick;
    chk({pin_oe, pin_out}, {core_oe, core_out});
    config_busy = 1'b0;
    $display("test pins done");
    n_pulse = 0;
    ir(`BSIU_OP_PULSE);
    chk(n_pulse, 1);
    chk(cs_oe, 1'b0);
    config_busy = 1'b1;
    n_abort = 0;
    ir(`BSIU_OP_CFGIO);
    chk(n_abort, 1);
    chk(cs_oe, 1'b1);
    q = $urandom;
    bsiu_host_i.scan(1'b0, 2*N, q, d);
    chk(d[7:0], 8'h00);
    chk(io_std, q[7:0]);
    config_busy = 1'b0;
    ir(`BSIU_OP_BYPASS);
    chk({cs_oe, cs_out}, 2'b10);
    cfg_done = 1'b1;
    tick;
    cfg_done = 1'b0;
    repeat (2) tick;
    chk(cs_oe, 1'b0);
    $display("test status done");
    // three bytes into a two-entry buffer while the sink stalls
    ir(`BSIU_OP_CFGLOAD);
    q = $urandom;
    bsiu_host_i.scan(1'b0, 24, q, d);
    chk({cfg_valid, cfg_overrun}, 2'b11);
    for (int k = 0; k < 2; k++) begin
      for (int w = 0; w < 20 && cfg_valid !== 1'b1; w++) tick;
      chk(cfg_valid, 1'b1);
      chk(cfg_data, q[8*k +: 8]);
      cfg_ready = 1'b1;
      tick;
      cfg_ready = 1'b0;
      tick;
    end
    chk(cfg_valid, 1'b0);
    bsiu_host_i.tap_reset();
    chk(cfg_overrun, 1'b0);
    $display("test config load done");
    report_and_stop();
  end
endmodule
